// ### hw/rmrb_buf_mem.sv
/*
 Single-port-per-direction byte memory of the baseband buffer.
 Assumes one write and one read port on one clock; read data is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module rmrb_buf_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } rmrb_mem_state_t;

  rmrb_mem_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.mem[waddr] = wdata;
    end
    if (re) begin
      s_d.rdata = s_q.mem[raddr];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
endmodule
`default_nettype wire

// ### hw/rmrb_defs.svh
/*
 Register indices, field positions, reset values and state codes of the
 radio mode register bank. Assumes inclusion by bare name from hw/.
*/
`ifndef RMRB_DEFS_SVH
`define RMRB_DEFS_SVH

// Register indices; byte address on APB is four times the index
`define RMRB_IDX_BUF 6'h00
`define RMRB_IDX_OPMODE 6'h01
`define RMRB_IDX_RSV_LO 6'h02
`define RMRB_IDX_RSV_HI 6'h05
`define RMRB_IDX_FRF_H 6'h06
`define RMRB_IDX_FRF_M 6'h07
`define RMRB_IDX_FRF_L 6'h08
`define RMRB_IDX_PAGE_LO 6'h0D
`define RMRB_IDX_PAGE_HI 6'h3F

// Operating-state control fields
`define RMRB_MODEM_BIT 7
`define RMRB_ALT_BIT 6
`define RMRB_MODE_MSB 2

// Reset values
`define RMRB_BUF_RST 8'h00
`define RMRB_OPMODE_RST 8'h01
`define RMRB_FRF_H_RST 8'hE4
`define RMRB_FRF_M_RST 8'hC0
`define RMRB_FRF_L_RST 8'h00
`define RMRB_SYNTH_RST 24'hE4C000

// Device state codes
`define RMRB_ST_SLEEP 3'h0
`define RMRB_ST_STANDBY 3'h1
`define RMRB_ST_TX_SYNTH 3'h2
`define RMRB_ST_TX 3'h3
`define RMRB_ST_RX_SYNTH 3'h4
`define RMRB_ST_RX_STREAM 3'h5
`define RMRB_ST_RX_ONE_SHOT 3'h6
`define RMRB_ST_CHAN_CHECK 3'h7

// Read transfers carry this many wait states
`define RMRB_READ_WAIT 1

`endif

// ### hw/rmrb_pkg.sv
/*
 Types of the radio mode register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rmrb_pkg;
  typedef enum logic {
    RMRB_IDLE,
    RMRB_RD_WAIT
  } rmrb_phase_t;
endpackage
`default_nettype wire

// ### hw/rmrb_top.sv
/*
 APB register bank of the radio in spread-spectrum mode: buffer data port,
 operating-state control, reserved words and the carrier frequency word.
 Assumes an APB master on clk, synchronous active-low reset, and an outside
 decoder that uses fsk_page_sel for the pages at indices 0x0D..0x3F.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rmrb_defs.svh"

// Notes on behaviour
// - Index 0x00 is a byte port writing into and reading from the baseband buffer.
// - In sleep the buffer is emptied and its data port does nothing.
// - Bit 7 picks the modem, resets 0, changes only when written in sleep.
// - The selected modem's register page is visible to the host unless bit 6 is set with the spread modem.
// - With the spread modem, bit 6 set maps indices 0x0D..0x3F to the FSK page, clear to spread page.
// - Bit 6 steers decoding only with the spread-spectrum modem selected; resets 0.
// - Bits 2..0 hold the eight device states; register resets to 0x01.
// - Carrier word stored high byte first at 0x06..0x08, reset 0xE4C000.
// - Carrier equals reference times word over two to the nineteenth.
module rmrb_top #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic modem_select,
  output logic alternate_page_access,
  output logic fsk_page_sel,
  output logic [2:0] device_state,
  output logic state_change,
  output logic [23:0] synth_word,
  output logic synth_load,
  output logic [$clog2(DEPTH):0] buf_level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  typedef struct packed {
    rmrb_pkg::rmrb_phase_t phase;
    logic [31:0] prdata;
    logic modem;
    logic alt;
    logic [2:0] mode;
    logic [7:0] frf_h;
    logic [7:0] frf_m;
    logic [7:0] frf_l;
    logic [23:0] synth;
    logic load;
    logic chg;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rmrb_state_t;

  localparam rmrb_state_t S_RST = '{
    phase: rmrb_pkg::RMRB_IDLE,
    modem: 1'(`RMRB_OPMODE_RST >> `RMRB_MODEM_BIT),
    mode: 3'(`RMRB_OPMODE_RST),
    frf_h: `RMRB_FRF_H_RST,
    frf_m: `RMRB_FRF_M_RST,
    frf_l: `RMRB_FRF_L_RST,
    synth: `RMRB_SYNTH_RST,
    default: '0
  };

  rmrb_state_t s_q, s_d;

  logic [5:0] idx;
  logic aligned;
  logic access;
  logic wr_done;
  logic rd_done;
  logic asleep;
  logic buf_empty;
  logic buf_full;
  logic push;
  logic mem_re;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;

  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign access = psel & penable;
  // Writes finish in the first access cycle, reads after one wait state
  assign pready = pwrite | (s_q.phase == rmrb_pkg::RMRB_RD_WAIT);
  // Misaligned transfers end with an error and change nothing
  assign pslverr = access & pready & ~aligned;
  assign wr_done = access & pwrite & aligned & pstrb[0];
  assign rd_done = access & ~pwrite & pready;
  assign asleep = (s_q.mode == `RMRB_ST_SLEEP);
  assign buf_empty = (s_q.cnt == '0);
  assign buf_full = (s_q.cnt == FULL_CNT);

  // Buffer is held inert while asleep
  assign push = wr_done & (idx == `RMRB_IDX_BUF) & ~asleep & ~buf_full;
  // Read is issued in the setup cycle so the byte is ready by the wait state
  assign mem_re = psel & ~penable & ~pwrite & (idx == `RMRB_IDX_BUF);

  rmrb_buf_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .we(push),
    .waddr(s_q.wp),
    .wdata(pwdata[7:0]),
    .re(mem_re),
    .raddr(s_q.rp),
    .rdata(mem_rdata)
  );

  // Read mux; anything outside this bank, including the shared pages, reads zero
  always_comb begin
    rd_byte = 8'h00;
    if (idx == `RMRB_IDX_BUF) begin
      if (!asleep && !buf_empty) begin
        rd_byte = mem_rdata;
      end
    end else if (idx == `RMRB_IDX_OPMODE) begin
      rd_byte = {s_q.modem, s_q.alt, 3'h0, s_q.mode};
    end else if (idx >= `RMRB_IDX_RSV_LO && idx <= `RMRB_IDX_RSV_HI) begin
      rd_byte = 8'h00;
    end else if (idx == `RMRB_IDX_FRF_H) begin
      rd_byte = s_q.frf_h;
    end else if (idx == `RMRB_IDX_FRF_M) begin
      rd_byte = s_q.frf_m;
    end else if (idx == `RMRB_IDX_FRF_L) begin
      rd_byte = s_q.frf_l;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    s_d.chg = 1'b0;

    case (s_q.phase)
      rmrb_pkg::RMRB_IDLE: begin
        if (access && !pwrite) begin
          s_d.phase = rmrb_pkg::RMRB_RD_WAIT;
          s_d.prdata = {24'h000000, rd_byte};
        end
      end
      rmrb_pkg::RMRB_RD_WAIT: begin
        s_d.phase = rmrb_pkg::RMRB_IDLE;
      end
      default: begin
        s_d.phase = rmrb_pkg::RMRB_IDLE;
      end
    endcase

    // Pop at read completion
    if (rd_done && aligned && idx == `RMRB_IDX_BUF && !asleep && !buf_empty) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (push && !(rd_done && aligned && idx == `RMRB_IDX_BUF && !buf_empty)) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (!push && rd_done && aligned && idx == `RMRB_IDX_BUF && !asleep && !buf_empty) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end

    if (wr_done) begin
      if (idx == `RMRB_IDX_OPMODE) begin
        // Modem choice is frozen outside sleep, judged on the state before the write
        if (asleep) begin
          s_d.modem = pwdata[`RMRB_MODEM_BIT];
        end
        s_d.alt = pwdata[`RMRB_ALT_BIT];
        s_d.mode = pwdata[`RMRB_MODE_MSB:0];
        s_d.chg = 1'b1;
      end else if (idx == `RMRB_IDX_FRF_H) begin
        s_d.frf_h = pwdata[7:0];
      end else if (idx == `RMRB_IDX_FRF_M) begin
        s_d.frf_m = pwdata[7:0];
      end else if (idx == `RMRB_IDX_FRF_L) begin
        s_d.frf_l = pwdata[7:0];
        // Committing on the low byte keeps the synthesizer from seeing a torn word
        s_d.synth = {s_q.frf_h, s_q.frf_m, pwdata[7:0]};
        s_d.load = 1'b1;
      end
    end

    // Flush while asleep wins over any stale pointer state
    if (asleep) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign modem_select = s_q.modem;
  assign alternate_page_access = s_q.alt;
  // Shared pages follow the FSK map unless the spread modem runs without bit 6
  assign fsk_page_sel = ~s_q.modem | s_q.alt;
  assign device_state = s_q.mode;
  assign state_change = s_q.chg;
  // Carrier in Hz is reference times synth_word over 2**19
  assign synth_word = s_q.synth;
  assign synth_load = s_q.load;
  assign buf_level = s_q.cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sleep_flush_a: assert property ((s_q.mode == `RMRB_ST_SLEEP) [*2] |-> buf_level == '0)
    else $error("buffer not empty in sleep");

  sleep_ignore_a: assert property (wr_done && idx == `RMRB_IDX_BUF && asleep |=> buf_level == '0)
    else $error("buffer write took effect in sleep");

  modem_lock_a: assert property ($changed(modem_select) |-> $past(device_state) == `RMRB_ST_SLEEP)
    else $error("modem select changed outside sleep");

  state_write_a: assert property (wr_done && idx == `RMRB_IDX_OPMODE |=>
    state_change && device_state == $past(pwdata[2:0]))
    else $error("state write not applied or not signalled");

  page_map_a: assert property (modem_select && !alternate_page_access |-> !fsk_page_sel)
    else $error("spread page not selected");

  rsv_zero_a: assert property (rd_done && idx >= `RMRB_IDX_RSV_LO && idx <= `RMRB_IDX_RSV_HI |->
    prdata == 32'h00000000)
    else $error("reserved word read nonzero");

  synth_commit_a: assert property (wr_done && idx == `RMRB_IDX_FRF_L |=>
    synth_load && synth_word[7:0] == $past(pwdata[7:0]))
    else $error("low byte write did not commit word");

  synth_hold_a: assert property ($changed(synth_word) |-> synth_load)
    else $error("synth word changed without commit");

  read_wait_a: assert property (access && !pwrite && !pready |=> pready)
    else $error("read wait state too long");

  // Transfer timing: writes answer at once, reads after exactly one wait state
  write_ready_a: assert property (access && pwrite |-> pready)
    else $error("write not answered in first access cycle");

  read_phase_a: assert property (s_q.phase == rmrb_pkg::RMRB_RD_WAIT |=>
    s_q.phase == rmrb_pkg::RMRB_IDLE)
    else $error("read wait state repeated");

  misalign_err_a: assert property (access && pwrite && !aligned |-> pslverr && !wr_done)
    else $error("misaligned write not refused");

  // Read data is judged at completion, the only cycle in which prdata must stand
  read_upper_a: assert property (rd_done |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  empty_read_a: assert property (rd_done && idx == `RMRB_IDX_BUF && (asleep || buf_empty) |->
    prdata == 32'h00000000)
    else $error("empty or sleeping buffer read nonzero");

  opmode_read_a: assert property (rd_done && idx == `RMRB_IDX_OPMODE |->
    prdata[7:0] == {modem_select, alternate_page_access, 3'h0, device_state})
    else $error("operating state read mismatch");

  push_count_a: assert property (push |=> buf_level == $past(buf_level) + 1'b1)
    else $error("buffer write not counted");

  pop_count_a: assert property (rd_done && idx == `RMRB_IDX_BUF && aligned && !asleep && !buf_empty |=>
    buf_level == $past(buf_level) - 1'b1)
    else $error("buffer read not counted");

  level_bound_a: assert property (buf_level <= FULL_CNT)
    else $error("buffer level beyond depth");

  full_hold_a: assert property (wr_done && idx == `RMRB_IDX_BUF && buf_full && !asleep |=>
    buf_level == FULL_CNT)
    else $error("write into full buffer counted");

  state_pulse_a: assert property (state_change |-> $past(wr_done && idx == `RMRB_IDX_OPMODE))
    else $error("sequencer pulse without state write");

  load_pulse_a: assert property (synth_load |-> $past(wr_done && idx == `RMRB_IDX_FRF_L))
    else $error("synthesizer load without low byte write");

  modem_write_a: assert property (wr_done && idx == `RMRB_IDX_OPMODE && asleep |=>
    modem_select == $past(pwdata[`RMRB_MODEM_BIT]))
    else $error("modem select not written in sleep");

  page_write_a: assert property (wr_done && idx == `RMRB_IDX_OPMODE |=>
    alternate_page_access == $past(pwdata[`RMRB_ALT_BIT]))
    else $error("page access bit not written");

  fsk_mode_page_a: assert property (!modem_select |-> fsk_page_sel)
    else $error("spread page reachable in FSK mode");

  alt_page_a: assert property (modem_select && alternate_page_access |-> fsk_page_sel)
    else $error("alternate page not selected");

  carrier_high_a: assert property (wr_done && idx == `RMRB_IDX_FRF_H |=>
    s_q.frf_h == $past(pwdata[7:0]))
    else $error("carrier high byte not stored");

  carrier_mid_a: assert property (wr_done && idx == `RMRB_IDX_FRF_M |=>
    s_q.frf_m == $past(pwdata[7:0]))
    else $error("carrier middle byte not stored");

  rsv_ignore_a: assert property (wr_done && idx >= `RMRB_IDX_RSV_LO && idx <= `RMRB_IDX_RSV_HI |=>
    $stable({s_q.modem, s_q.alt, s_q.mode, s_q.frf_h, s_q.frf_m, s_q.frf_l, s_q.cnt}))
    else $error("reserved write changed a register");

  // Scenario covers: buffer traffic, modem switch, alternate page and an opmode write while in sleep
  push_cov: cover property (push);
  pop_cov: cover property (rd_done && idx == `RMRB_IDX_BUF && !buf_empty && !asleep);
  modem_cov: cover property ($rose(modem_select));
  page_cov: cover property (modem_select && alternate_page_access);
  sleep_cov: cover property (wr_done && idx == `RMRB_IDX_OPMODE && asleep);
endmodule
`default_nettype wire

// ### testbench/rmrb_tb.sv
/*
 Self-checking bench for the radio mode register bank: APB reads and writes,
 mode field, modem and page bits, buffer port, reserved words, carrier word.
 Assumes hw/ on the include path and rmrb_top with DEPTH 16.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rmrb_defs.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] strb_v = 4'hF;
  logic last_err = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, modem_select, alternate_page_access, fsk_page_sel, state_change, synth_load;
  logic [2:0] device_state;
  logic [23:0] synth_word;
  logic [4:0] buf_level;
  logic [31:0] exp_q[$];
  logic [7:0] b[3];
  int fails = 0;
  int checks_done = 0;

  rmrb_top #(.DEPTH(16)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_select(modem_select), .alternate_page_access(alternate_page_access), .fsk_page_sel(fsk_page_sel),
    .device_state(device_state), .state_change(state_change), .synth_word(synth_word),
    .synth_load(synth_load), .buf_level(buf_level));

  always #12.5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Every transfer starts at least one edge after the last ended, so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb_v;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    last_err = pslverr;
    if (n >= 50) check(0, 1, "pready timeout");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Opmode write, then the sequencer pulse and the state it should have seen
  task automatic op(input logic [7:0] v, input logic [7:0] e);
    wr(8'h04, {24'h0, v});
    #1;
    check(state_change, 1, "state pulse");
    check(device_state, e[2:0], "state");
    rd(8'h04, {24'h0, e});
  endtask

  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) check(0, 1, "unexpected read");
      else check(prdata, exp_q.pop_front(), "read data");
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h2C78));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(synth_word, `RMRB_SYNTH_RST, "synth reset");
    rd(8'h04, `RMRB_OPMODE_RST);
    rd(8'h18, `RMRB_FRF_H_RST);
    rd(8'h1C, `RMRB_FRF_M_RST);
    rd(8'h20, `RMRB_FRF_L_RST);
    for (int i = 2; i <= 5; i++) begin
      wr(8'(i * 4), $urandom);
      rd(8'(i * 4), 32'h0);
    end
    rd(8'h24, 32'h0);
    $display("reset and reserved done");
    op(8'h81, 8'h01);
    op(8'h00, 8'h00);
    op(8'h80, 8'h80);
    check(fsk_page_sel, 0, "page spread");
    op(8'hC1, 8'hC1);
    check(fsk_page_sel, 1, "page fsk");
    check({modem_select, alternate_page_access}, 2'b11, "modem and page bits");
    op(8'h01, 8'h81);
    check(fsk_page_sel, 0, "page back");
    check({modem_select, alternate_page_access}, 2'b10, "page bit cleared");
    for (int s = 1; s < 8; s++) op(8'(8'h80 | s), 8'(8'h80 | s));
    $display("mode field done");
    op(8'h81, 8'h81);
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      wr(8'h00, {24'h0, b[i]});
    end
    repeat (2) @(posedge clk);
    #1;
    check(buf_level, 3, "level");
    foreach (b[i]) rd(8'h00, {24'h0, b[i]});
    wr(8'h00, 32'h5A);
    op(8'h80, 8'h80);
    repeat (2) @(posedge clk);
    #1;
    check(buf_level, 0, "flush");
    wr(8'h00, 32'hA5);
    rd(8'h00, 32'h0);
    #1;
    check(buf_level, 0, "sleep write");
    $display("buffer done");
    foreach (b[i]) b[i] = 8'($urandom);
    wr(8'h18, {24'h0, b[0]});
    wr(8'h1C, {24'h0, b[1]});
    #1;
    check(synth_word, `RMRB_SYNTH_RST, "no early commit");
    wr(8'h20, {24'h0, b[2]});
    #1;
    check(synth_load, 1, "load pulse");
    check(synth_word, {b[0], b[1], b[2]}, "commit");
    check(last_err, 0, "aligned write error");
    strb_v = 4'h0;
    wr(8'h18, 32'h0);
    strb_v = 4'hF;
    wr(8'h1A, 32'h0000005A);
    check(last_err, 1, "misaligned error");
    rd(8'h18, {24'h0, b[0]});
    rd(8'h1C, {24'h0, b[1]});
    rd(8'h20, {24'h0, b[2]});
    repeat (2) @(posedge clk);
    $display("carrier done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
